// ==== hdl/sle_consts.vh ====
// constants for the status indicator encoder
`ifndef SLE_CONSTS_VH
`define SLE_CONSTS_VH

`define SLE_CLK_HZ          250000000
`define SLE_ATTN_HZ         1
`define SLE_FAULT_HZ        2
`define SLE_BOOT_HZ         1
// half periods in clock cycles
`define SLE_ATTN_HALF       (`SLE_CLK_HZ / (2 * `SLE_ATTN_HZ))
`define SLE_FAULT_HALF      (`SLE_CLK_HZ / (2 * `SLE_FAULT_HZ))
`define SLE_BOOT_HALF       (`SLE_CLK_HZ / (2 * `SLE_BOOT_HZ))

// system indicator colour codes
`define SLE_COL_OFF         2'h0
`define SLE_COL_GREEN       2'h1
`define SLE_COL_YELLOW      2'h2
`define SLE_COL_RED         2'h3

// fault category codes
`define SLE_CAT_NONE        4'h0
`define SLE_CAT_MEMORY      4'h1
`define SLE_CAT_FIRMWARE    4'h2
`define SLE_CAT_BOARD       4'h3
`define SLE_CAT_FAN         4'h4
`define SLE_CAT_PROCESSOR   4'h5
`define SLE_CAT_BMC         4'h6
`define SLE_CAT_TEMP        4'h7
`define SLE_CAT_POWER       4'h8
`define SLE_CAT_UNKNOWN     4'h9

// red masks, bit 0 is indicator 1; one-hot for memory to fan, two or four bits set for the rest
`define SLE_RED_MEMORY      4'h1
`define SLE_RED_FIRMWARE    4'h2
`define SLE_RED_BOARD       4'h4
`define SLE_RED_FAN         4'h8
`define SLE_RED_PROCESSOR   4'h3
`define SLE_RED_BMC         4'h5
`define SLE_RED_TEMP        4'h9
`define SLE_RED_POWER       4'ha
`define SLE_RED_UNKNOWN     4'hf

`endif

// ==== hdl/sle_blinker.v ====
// square wave generator with a programmable half period
`timescale 1ns/100ps
`default_nettype none

module sle_blinker #(
    parameter HALF = 125000000
) (
    input  wire clock,
    input  wire srst,
    output reg  wave_q
);
    reg [31:0] count_q;

    // equal on and off times
    always @(posedge clock) begin
        if (srst) begin
            count_q <= 32'h0000_0000;
            wave_q  <= 1'b0;
        end else if (count_q == HALF - 1) begin
            count_q <= 32'h0000_0000;
            wave_q  <= ~wave_q;
        end else begin
            count_q <= count_q + 32'h0000_0001;
        end
    end
endmodule

`default_nettype wire

// ==== hdl/sle_top.v ====
// front panel status and diagnostic indicator encoder
`timescale 1ns/100ps
`default_nettype none
`include "sle_consts.vh"

module sle_top #(
    parameter ATTN_HALF  = `SLE_ATTN_HALF,
    parameter FAULT_HALF = `SLE_FAULT_HALF,
    parameter BOOT_HALF  = `SLE_BOOT_HALF
) (
    input  wire       clock,
    input  wire       srst,
    input  wire       ac_power_on,
    input  wire       booting,
    input  wire       os_running,
    input  wire       boot_console_prompt,
    input  wire       boot_success,
    input  wire       alert_warn_pulse,
    input  wire       alert_l7_pulse,
    input  wire       fatal_error,
    input  wire       log_view_command,
    input  wire       fault_clear_command,
    input  wire       management_card,
    input  wire [3:0] diag_category,
    input  wire [3:0] diag_detail_green,
    output reg  [1:0] sys_colour_q,
    output reg        sys_lit_q,
    output reg  [3:0] diag_red_q,
    output reg  [3:0] diag_green_q,
    output reg        attention_q,
    output reg        fault_q
);
    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    localparam NIN = 11;
    wire [NIN-1:0] raw_in;
    reg  [NIN-1:0] meta_q;
    reg  [NIN-1:0] sync_q;
    reg  [NIN-1:0] prev_q;

    assign raw_in = {ac_power_on, booting, os_running, boot_console_prompt,
                     boot_success, alert_warn_pulse, alert_l7_pulse, fatal_error,
                     log_view_command, fault_clear_command, management_card};

    always @(posedge clock) begin
        if (srst) begin
            meta_q <= {NIN{1'b0}};
            sync_q <= {NIN{1'b0}};
            prev_q <= {NIN{1'b0}};
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    wire s_power    = sync_q[10];
    wire s_boot     = sync_q[9];
    wire s_os       = sync_q[8];
    wire s_prompt   = sync_q[7];
    wire e_boot_ok  = sync_q[6] & ~prev_q[6];
    wire e_warn     = sync_q[5] & ~prev_q[5];
    wire e_l7       = sync_q[4] & ~prev_q[4];
    wire s_fatal    = sync_q[3];
    wire e_logview  = sync_q[2] & ~prev_q[2];
    wire e_clear    = sync_q[1] & ~prev_q[1];
    wire s_card     = sync_q[0];

    reg [3:0] cat_meta_q;
    reg [3:0] cat_sync_q;
    reg [3:0] cat_hold_q;
    reg [3:0] cat_q;
    reg [3:0] grn_meta_q;
    reg [3:0] grn_q;

    always @(posedge clock) begin
        if (srst) begin
            cat_meta_q <= `SLE_CAT_NONE;
            cat_sync_q <= `SLE_CAT_NONE;
            cat_hold_q <= `SLE_CAT_NONE;
            cat_q      <= `SLE_CAT_NONE;
            grn_meta_q <= 4'h0;
            grn_q      <= 4'h0;
        end else begin
            cat_meta_q <= diag_category;
            cat_sync_q <= cat_meta_q;
            cat_hold_q <= cat_sync_q;
            // code taken only once two samples agree
            if (cat_sync_q == cat_hold_q)
                cat_q <= cat_sync_q;
            grn_meta_q <= diag_detail_green;
            grn_q      <= grn_meta_q;
        end
    end

    // --------------------------------------------------------------
    // blink sources
    // --------------------------------------------------------------
    wire attn_wave;
    wire fault_wave;
    wire boot_wave;

    sle_blinker #(.HALF(ATTN_HALF)) u_attn (
        .clock  (clock),
        .srst   (srst),
        .wave_q (attn_wave)
    );

    sle_blinker #(.HALF(FAULT_HALF)) u_fault (
        .clock  (clock),
        .srst   (srst),
        .wave_q (fault_wave)
    );

    sle_blinker #(.HALF(BOOT_HALF)) u_boot (
        .clock  (clock),
        .srst   (srst),
        .wave_q (boot_wave)
    );

    // --------------------------------------------------------------
    // sticky attention and level 7 state; fault_q also follows the fatal_error level
    // --------------------------------------------------------------
    reg l7_q;
    reg attn_d;
    reg l7_d;

    always @* begin
        attn_d = attention_q;
        if (e_logview)
            attn_d = 1'b0;
        if (e_warn)
            attn_d = 1'b1;
        l7_d = l7_q;
        if (e_clear || e_boot_ok)
            l7_d = 1'b0;
        if (e_l7)
            l7_d = 1'b1;
    end

    always @(posedge clock) begin
        if (srst) begin
            attention_q <= 1'b0;
            l7_q        <= 1'b0;
            fault_q     <= 1'b0;
        end else begin
            attention_q <= attn_d;
            l7_q        <= l7_d;
            fault_q     <= l7_d | s_fatal;
        end
    end

    // --------------------------------------------------------------
    // boot progress sequencer
    // --------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_STEP = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [2:0] step_q;
    reg [2:0] step_d;
    reg       boot_wave_prev_q;
    wire      step_tick = boot_wave & ~boot_wave_prev_q;

    always @* begin
        state_d = state_q;
        step_d  = step_q;
        case (state_q)
            ST_IDLE: begin
                if (s_boot) begin
                    state_d = ST_STEP;
                    step_d  = 3'd1;
                end
            end
            ST_STEP: begin
                if (!s_boot || s_prompt) begin
                    state_d = ST_DONE;
                    step_d  = 3'd0;
                end else if (step_tick && step_q != 3'd4) begin
                    step_d = step_q + 3'd1;
                end
            end
            default: begin
                if (!s_boot && !s_prompt)
                    state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        if (srst) begin
            state_q          <= ST_IDLE;
            step_q           <= 3'd0;
            boot_wave_prev_q <= 1'b0;
        end else begin
            state_q          <= state_d;
            step_q           <= step_d;
            boot_wave_prev_q <= boot_wave;
        end
    end

    // --------------------------------------------------------------
    // diagnostic indicator encoding
    // --------------------------------------------------------------
    reg [3:0] red_mask;
    reg [3:0] red_d;
    reg [3:0] green_d;

    always @* begin
        if (cat_q == `SLE_CAT_MEMORY)
            red_mask = `SLE_RED_MEMORY;
        else if (cat_q == `SLE_CAT_FIRMWARE)
            red_mask = `SLE_RED_FIRMWARE;
        else if (cat_q == `SLE_CAT_BOARD)
            red_mask = `SLE_RED_BOARD;
        else if (cat_q == `SLE_CAT_FAN)
            red_mask = `SLE_RED_FAN;
        else if (cat_q == `SLE_CAT_PROCESSOR)
            red_mask = `SLE_RED_PROCESSOR;
        else if (cat_q == `SLE_CAT_BMC)
            red_mask = `SLE_RED_BMC;
        else if (cat_q == `SLE_CAT_TEMP)
            red_mask = `SLE_RED_TEMP;
        else if (cat_q == `SLE_CAT_POWER)
            red_mask = `SLE_RED_POWER;
        else if (cat_q == `SLE_CAT_UNKNOWN)
            red_mask = `SLE_RED_UNKNOWN;
        else
            red_mask = 4'h0;
    end

    always @* begin
        red_d   = 4'h0;
        green_d = 4'h0;
        if (!s_power) begin
            red_d   = 4'h0;
            green_d = 4'h0;
        end else if ((fault_q || attention_q) && red_mask != 4'h0) begin
            red_d   = red_mask;
            green_d = grn_q & ~red_mask;
        end else if (state_q == ST_STEP && !s_card) begin
            // progress bar: indicators 1..step lit green
            green_d = (4'h1 << step_q[1:0]) - 4'h1;
            if (step_q == 3'd4)
                green_d = 4'hf;
        end else if (state_q == ST_STEP && s_card) begin
            green_d = 4'h0;
        end
    end

    // --------------------------------------------------------------
    // system indicator
    // --------------------------------------------------------------
    reg [1:0] col_d;
    reg       lit_d;

    always @* begin
        col_d = `SLE_COL_OFF;
        lit_d = 1'b0;
        if (!s_power) begin
            col_d = `SLE_COL_OFF;
            lit_d = 1'b0;
        end else if (fault_q) begin
            col_d = `SLE_COL_RED;
            lit_d = fault_wave;
        end else if (attention_q) begin
            col_d = `SLE_COL_YELLOW;
            lit_d = attn_wave;
        end else if (s_os) begin
            col_d = `SLE_COL_GREEN;
            lit_d = 1'b1;
        end else if (s_boot) begin
            col_d = `SLE_COL_GREEN;
            lit_d = boot_wave;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            sys_colour_q <= `SLE_COL_OFF;
            sys_lit_q    <= 1'b0;
            diag_red_q   <= 4'h0;
            diag_green_q <= 4'h0;
        end else begin
            sys_colour_q <= col_d;
            sys_lit_q    <= lit_d;
            diag_red_q   <= red_d;
            diag_green_q <= green_d;
        end
    end
endmodule

`default_nettype wire

// ==== dv/sle_top_assertions.sv ====
// concurrent checks on the status indicator encoder ports
`timescale 1ns/100ps
`default_nettype none
module sle_top_checker (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       ac_power_on,
    input wire logic       alert_warn_pulse,
    input wire logic       alert_l7_pulse,
    input wire logic       fatal_error,
    input wire logic       log_view_command,
    input wire logic       fault_clear_command,
    input wire logic       management_card,
    input wire logic [3:0] diag_detail_green,
    input wire logic [1:0] sys_colour_q,
    input wire logic [3:0] diag_red_q,
    input wire logic [3:0] diag_green_q,
    input wire logic       attention_q,
    input wire logic       fault_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_dark_no_power: assert property ((!ac_power_on)[*6] |-> sys_colour_q == 2'h0)
        else $error("system lamp lit without power");
    a_fault_red: assert property ((ac_power_on && fault_q)[*6] |-> sys_colour_q == 2'h3)
        else $error("fault not shown red");
    a_attn_yellow: assert property ((ac_power_on && attention_q && !fault_q)[*6] |-> sys_colour_q == 2'h2)
        else $error("attention not shown yellow");
    a_warn_sets: assert property ($rose(alert_warn_pulse) |-> ##[2:4] attention_q)
        else $error("warning alert did not set attention");
    a_fatal_fault: assert property (fatal_error[*4] |-> fault_q)
        else $error("fatal error not held as fault");
    a_view_clears: assert property ($rose(log_view_command) ##1 (!alert_warn_pulse)[*4] |-> !attention_q)
        else $error("log view did not clear attention");
    a_clear_level7: assert property ($rose(fault_clear_command) && !fatal_error
        ##1 (!fatal_error && !alert_l7_pulse)[*5] |-> !fault_q)
        else $error("fault clear did not clear fault");
    a_no_overlap: assert property ((diag_red_q & diag_green_q) == 4'h0)
        else $error("diagnostic lamp red and green together");
    a_red_needs_sev: assert property (diag_red_q != 4'h0 |->
        fault_q || attention_q || $past(fault_q || attention_q))
        else $error("diagnostic red without warning or fault");
    a_card_dark: assert property ((management_card && !fault_q && !attention_q && diag_detail_green == 4'h0)[*6]
        |-> diag_red_q == 4'h0 && diag_green_q == 4'h0)
        else $error("diagnostic lamps lit with card fitted");
endmodule
bind sle_top sle_top_checker chk_i (.clock, .srst, .ac_power_on, .alert_warn_pulse, .alert_l7_pulse,
    .fatal_error, .log_view_command, .fault_clear_command, .management_card, .diag_detail_green,
    .sys_colour_q, .diag_red_q, .diag_green_q, .attention_q, .fault_q);
`default_nettype wire

// ==== dv/sle_lamp_model.sv ====
// lamp model measuring on and off phase lengths in cycles
`timescale 1ns/100ps
`default_nettype none
module sle_lamp_model (
    input  wire logic clock,
    input  wire logic lit,
    output var  int   on_len,
    output var  int   off_len
);
    int   run_q = 0;
    logic lit_q = 1'b0;
    always @(posedge clock) begin
        lit_q <= lit;
        run_q <= (lit != lit_q) ? 1 : run_q + 1;
        if (lit != lit_q && lit)
            off_len <= run_q;
        if (lit != lit_q && !lit)
            on_len <= run_q;
    end
endmodule
`default_nettype wire

// ==== dv/sle_top_bench.sv ====
// self-checking bench for the status indicator encoder
`timescale 1ns/100ps
`default_nettype none
`include "sle_consts.vh"
module sle_top_bench;
    localparam AH = 4;
    localparam FH = 2;
    localparam BH = 4;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       ac_power_on, booting, os_running, boot_console_prompt, boot_success;
    logic       alert_warn_pulse, alert_l7_pulse, fatal_error, log_view_command;
    logic       fault_clear_command, management_card, sys_lit_q, attention_q, fault_q;
    logic [3:0] diag_category, diag_detail_green, diag_red_q, diag_green_q, seen;
    logic [1:0] sys_colour_q;
    int         n_fail = 0, comparisons = 0, on_len, off_len;
    // category, detail, expected red, expected green
    logic [15:0] rows [12] = '{16'h1f1e, 16'h2f2d, 16'h3f4b, 16'h4f87, 16'h5f3c, 16'h6f5a,
                               16'h7f96, 16'h8fa5, 16'h9ff0, 16'h1212, 16'h4181, 16'h0000};
    sle_top #(.ATTN_HALF(AH), .FAULT_HALF(FH), .BOOT_HALF(BH)) dut (.clock, .srst, .ac_power_on,
        .booting, .os_running, .boot_console_prompt, .boot_success, .alert_warn_pulse, .alert_l7_pulse,
        .fatal_error, .log_view_command, .fault_clear_command, .management_card, .diag_category,
        .diag_detail_green, .sys_colour_q, .sys_lit_q, .diag_red_q, .diag_green_q, .attention_q, .fault_q);
    sle_lamp_model lamp (.clock, .lit(sys_lit_q), .on_len, .off_len);
    always #2 clock = ~clock;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(2);
        s = 1'b0;
        tick(10);
    endtask
    task automatic blink(input int h);
        tick(4 * h + 4);
        chk("on_len", h[7:0], on_len[7:0]);
        chk("off_len", h[7:0], off_len[7:0]);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {ac_power_on, booting, os_running, boot_console_prompt, boot_success, alert_warn_pulse} = '0;
        {alert_l7_pulse, fatal_error, log_view_command, fault_clear_command, management_card} = '0;
        {diag_category, diag_detail_green} = '0;
        tick(20);
        srst = 1'b0;
        ac_power_on = 1'b1;
        pulse(alert_warn_pulse);
        chk("attention", 1, attention_q);
        chk("colour", `SLE_COL_YELLOW, sys_colour_q);
        blink(AH);
        foreach (rows[i]) begin
            {diag_category, diag_detail_green} = rows[i][15:8];
            tick(8);
            chk("diag_red", rows[i][7:4], diag_red_q);
            chk("diag_green", rows[i][3:0], diag_green_q);
        end
        $display("done: categories");
        pulse(log_view_command);
        chk("attention", 0, attention_q);
        chk("colour", `SLE_COL_OFF, sys_colour_q);
        chk("lit", 0, sys_lit_q);
        pulse(alert_warn_pulse);
        pulse(alert_l7_pulse);
        chk("colour", `SLE_COL_RED, sys_colour_q);
        blink(FH);
        pulse(boot_success);
        chk("fault", 0, fault_q);
        chk("colour", `SLE_COL_YELLOW, sys_colour_q);
        pulse(alert_l7_pulse);
        pulse(fault_clear_command);
        chk("fault", 0, fault_q);
        $display("done: level seven");
        fatal_error = 1'b1;
        tick(8);
        pulse(fault_clear_command);
        chk("fault", 1, fault_q);
        chk("colour", `SLE_COL_RED, sys_colour_q);
        ac_power_on = 1'b0;
        tick(8);
        chk("colour", `SLE_COL_OFF, sys_colour_q);
        chk("lit", 0, sys_lit_q);
        ac_power_on = 1'b1;
        fatal_error = 1'b0;
        tick(8);
        chk("fault", 0, fault_q);
        pulse(log_view_command);
        os_running = 1'b1;
        tick(8);
        chk("colour", `SLE_COL_GREEN, sys_colour_q);
        repeat (3 * AH) begin
            chk("lit", 1, sys_lit_q);
            tick(1);
        end
        os_running = 1'b0;
        booting = 1'b1;
        seen = 4'h0;
        for (int i = 0; i < 200 && seen != 4'hf; i++) begin
            if (diag_green_q !== seen) begin
                chk("progress", {seen[2:0], 1'b1}, diag_green_q);
                seen = diag_green_q;
            end
            tick(1);
        end
        if (seen != 4'hf) begin
            chk("progress_end", 8'h0f, {4'h0, seen});
            results();
        end
        chk("colour", `SLE_COL_GREEN, sys_colour_q);
        blink(BH);
        boot_console_prompt = 1'b1;
        tick(8);
        chk("progress", 0, diag_green_q);
        boot_console_prompt = 1'b0;
        booting = 1'b0;
        management_card = 1'b1;
        tick(8);
        booting = 1'b1;
        repeat (6 * BH) begin
            chk("card", 0, diag_green_q);
            tick(1);
        end
        $display("done: boot");
        fatal_error = 1'b1;
        tick(8);
        srst = 1'b1;
        tick(2);
        chk("reset", 0, {fault_q, attention_q, sys_lit_q, sys_colour_q, diag_red_q[2:0]});
        chk("reset_diag", 8'h00, {diag_red_q, diag_green_q});
        srst = 1'b0;
        tick(1);
        chk("fault_after_reset", 0, fault_q);
        tick(8);
        chk("fault", 1, fault_q);
        chk("colour", `SLE_COL_RED, sys_colour_q);
        $display("done: reset");
        results();
    end
endmodule
`default_nettype wire
